/* File: pkg/isc_regs.svh */
// Register indices, reset values, masks and protocol constants
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ISC_IDX_ID      8'h00
`define ISC_IDX_POWER   8'h01
`define ISC_IDX_DIGITAL 8'h02
`define ISC_IDX_FADE    8'h03
`define ISC_IDX_LVOL    8'h04
`define ISC_IDX_RVOL    8'h05
`define ISC_IDX_OUTSTG  8'h06
`define ISC_IDX_RSV7    8'h07
`define ISC_IDX_FAULT   8'h08
`define ISC_IDX_CLIPM   8'h10
`define ISC_IDX_CLIPL   8'h11

// ----------------------------------------------------------------
// Reset values, write masks and fixed bits
// ----------------------------------------------------------------
`define ISC_RST_POWER   8'hfd
`define ISC_RST_DIGITAL 8'h14
`define ISC_RST_FADE    8'h80
`define ISC_RST_VOL     8'hcf
`define ISC_RST_OUTSTG  8'h51
`define ISC_RST_FAULT   8'h00
`define ISC_RST_CLIPM   8'hff
`define ISC_RST_CLIPL   8'hfc
`define ISC_RST_ZERO    8'h00
`define ISC_WM_DIGITAL  8'hbf
`define ISC_WM_FADE     8'h83
`define ISC_WM_OUTSTG   8'hfe
`define ISC_WM_FAULT    8'hf0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISC_SLEEP_BIT   1
`define ISC_SHDN_N_BIT  0
`define ISC_HPF_BIT     7
`define ISC_RATE_BIT    3
`define ISC_FADE_BIT    7
`define ISC_MUTE_R_BIT  1
`define ISC_MUTE_L_BIT  0

// ----------------------------------------------------------------
// Format codes and protocol constants
// ----------------------------------------------------------------
`define ISC_FMT_RJ24    3'h0
`define ISC_FMT_RJ20    3'h1
`define ISC_FMT_RJ18    3'h2
`define ISC_FMT_RJ16    3'h3
`define ISC_FMT_I2S     3'h4
`define ISC_FMT_LJ      3'h5
`define ISC_ADDR_HI     6'h36
`define ISC_BYTE_BITS   4'h8
`define ISC_BIT_ONE     4'h1
`define ISC_BIT_ZERO    4'h0
`define ISC_BYTE_ADDR   2'h0
`define ISC_BYTE_INDEX  2'h1
`define ISC_BYTE_DATA   2'h2
`define ISC_STRAP_TAKE  2'h2
`define ISC_STRAP_DONE  2'h3

`endif

/* File: pkg/isc_pkg.sv */
// Types shared by the control port design files
package isc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } isc_state_t;

  typedef enum logic [2:0] {
    FMT_RJ24,
    FMT_RJ20,
    FMT_RJ18,
    FMT_RJ16,
    FMT_I2S,
    FMT_LJ,
    FMT_RSVD
  } isc_fmt_t;

endpackage

/* File: src/isc_regfile.sv */
// Configuration and status register file of the control port
`timescale 1ns/1ps
`include "isc_regs.svh"

module isc_regfile #(
  parameter logic [7:0] ID_CODE = 8'h5a   // Arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [7:0]        idx,
  input  wire logic [7:0]        wdata,
  input  wire logic [3:0]        fault_status,
  output logic [7:0]             rd_data,
  output logic                   low_power_standby_bit,
  output logic                   power_stage_off,
  output logic                   supplies_down,
  output logic                   hpf_bypass,
  output logic [1:0]             digital_boost,
  output logic                   rate_range_select,
  output isc_pkg::isc_fmt_t      audio_format,
  output logic                   fade_enable,
  output logic                   mute_right,
  output logic                   mute_left,
  output logic [7:0]             left_vol,
  output logic [7:0]             right_vol,
  output logic [6:0]             output_stage_bits,
  output logic [3:0]             fault_config_bits,
  output logic [19:0]            clip_threshold_level
);
  import isc_pkg::*;

  logic [7:0] power_and_clip_high;
  logic [7:0] digital_path_config;
  logic [7:0] fade_and_mute_config;
  logic [7:0] left_volume;
  logic [7:0] right_volume;
  logic [7:0] output_stage_config;
  logic [7:0] fault_config_status;
  logic [7:0] clip_level_middle;
  logic [7:0] clip_level_low;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire hit_power  = wr_en && (idx == `ISC_IDX_POWER);
  wire hit_dig    = wr_en && (idx == `ISC_IDX_DIGITAL);
  wire hit_fade   = wr_en && (idx == `ISC_IDX_FADE);
  wire hit_lvol   = wr_en && (idx == `ISC_IDX_LVOL);
  wire hit_rvol   = wr_en && (idx == `ISC_IDX_RVOL);
  wire hit_outstg = wr_en && (idx == `ISC_IDX_OUTSTG);
  wire hit_fault  = wr_en && (idx == `ISC_IDX_FAULT);
  wire hit_clipm  = wr_en && (idx == `ISC_IDX_CLIPM);
  wire hit_clipl  = wr_en && (idx == `ISC_IDX_CLIPL);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_and_clip_high  <= `ISC_RST_POWER;
      digital_path_config  <= `ISC_RST_DIGITAL;
      fade_and_mute_config <= `ISC_RST_FADE;
      left_volume          <= `ISC_RST_VOL;
      right_volume         <= `ISC_RST_VOL;
      output_stage_config  <= `ISC_RST_OUTSTG;
      fault_config_status  <= `ISC_RST_FAULT;
      clip_level_middle    <= `ISC_RST_CLIPM;
      clip_level_low       <= `ISC_RST_CLIPL;
    end else begin
      // Read-only and reserved bits keep their fixed values
      if (hit_power)  power_and_clip_high <= wdata;
      if (hit_dig)    digital_path_config <= (wdata & `ISC_WM_DIGITAL)
                        | (`ISC_RST_DIGITAL & ~`ISC_WM_DIGITAL);
      if (hit_fade)   fade_and_mute_config <= (wdata & `ISC_WM_FADE)
                        | (`ISC_RST_FADE & ~`ISC_WM_FADE);
      if (hit_lvol)   left_volume <= wdata;
      if (hit_rvol)   right_volume <= wdata;
      if (hit_outstg) output_stage_config <= (wdata & `ISC_WM_OUTSTG)
                        | (`ISC_RST_OUTSTG & ~`ISC_WM_OUTSTG);
      if (hit_fault)  fault_config_status <= wdata & `ISC_WM_FAULT;
      if (hit_clipm)  clip_level_middle <= wdata;
      if (hit_clipl)  clip_level_low <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign rd_data =
    (idx == `ISC_IDX_ID)      ? ID_CODE :
    (idx == `ISC_IDX_POWER)   ? power_and_clip_high :
    (idx == `ISC_IDX_DIGITAL) ? digital_path_config :
    (idx == `ISC_IDX_FADE)    ? fade_and_mute_config :
    (idx == `ISC_IDX_LVOL)    ? left_volume :
    (idx == `ISC_IDX_RVOL)    ? right_volume :
    (idx == `ISC_IDX_OUTSTG)  ? output_stage_config :
    (idx == `ISC_IDX_FAULT)   ? {fault_config_status[7:4], fault_status} :
    (idx == `ISC_IDX_CLIPM)   ? clip_level_middle :
    (idx == `ISC_IDX_CLIPL)   ? clip_level_low :
    `ISC_RST_ZERO;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  wire sleep_bit = power_and_clip_high[`ISC_SLEEP_BIT];
  wire run_bit   = power_and_clip_high[`ISC_SHDN_N_BIT];
  assign low_power_standby_bit = sleep_bit & run_bit;
  assign power_stage_off       = sleep_bit | ~run_bit;
  assign supplies_down         = ~run_bit;
  assign hpf_bypass            = digital_path_config[`ISC_HPF_BIT];
  assign digital_boost         = digital_path_config[5:4];
  assign rate_range_select     = digital_path_config[`ISC_RATE_BIT];
  assign fade_enable           = fade_and_mute_config[`ISC_FADE_BIT];
  assign mute_right            = fade_and_mute_config[`ISC_MUTE_R_BIT];
  assign mute_left             = fade_and_mute_config[`ISC_MUTE_L_BIT];
  assign left_vol              = left_volume;
  assign right_vol             = right_volume;
  assign output_stage_bits     = output_stage_config[7:1];
  assign fault_config_bits     = fault_config_status[7:4];
  assign clip_threshold_level  = {power_and_clip_high[7:2],
                                  clip_level_middle,
                                  clip_level_low[7:2]};

  wire [2:0] fmt_code = digital_path_config[2:0];
  assign audio_format =
    (fmt_code == `ISC_FMT_RJ24) ? FMT_RJ24 :
    (fmt_code == `ISC_FMT_RJ20) ? FMT_RJ20 :
    (fmt_code == `ISC_FMT_RJ18) ? FMT_RJ18 :
    (fmt_code == `ISC_FMT_RJ16) ? FMT_RJ16 :
    (fmt_code == `ISC_FMT_I2S)  ? FMT_I2S :
    (fmt_code == `ISC_FMT_LJ)   ? FMT_LJ : FMT_RSVD;

endmodule // isc_regfile

/* File: src/isc_control_port.sv */
// Slave-only two-wire control port with register file
`timescale 1ns/1ps
`include "isc_regs.svh"

module isc_control_port (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  input  wire logic              address_strap_pin,
  input  wire logic [3:0]        fault_status,
  output logic                   low_power_standby_bit,
  output logic                   power_stage_off,
  output logic                   supplies_down,
  output logic                   hpf_bypass,
  output logic [1:0]             digital_boost,
  output logic                   rate_range_select,
  output isc_pkg::isc_fmt_t      audio_format,
  output logic                   fade_enable,
  output logic                   mute_right,
  output logic                   mute_left,
  output logic [7:0]             left_vol,
  output logic [7:0]             right_vol,
  output logic [6:0]             output_stage_bits,
  output logic [3:0]             fault_config_bits,
  output logic [19:0]            clip_threshold_level
);
  import isc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] strap_sy;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy   <= 2'h3;
      sda_sy   <= 2'h3;
      strap_sy <= 2'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sy   <= {scl_sy[0], scl_in};
      sda_sy   <= {sda_sy[0], sda_in};
      strap_sy <= {strap_sy[0], address_strap_pin};
      scl_d    <= scl_sy[1];
      sda_d    <= sda_sy[1];
    end
  end

  wire scl_s      = scl_sy[1];
  wire sda_s      = sda_sy[1];
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Address strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt;
  logic       addr_lsb;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
      addr_lsb  <= 1'b0;
    end else if (strap_cnt != `ISC_STRAP_DONE) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `ISC_STRAP_TAKE) addr_lsb <= strap_sy[1];
    end
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  isc_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_sh;
  logic [1:0] byte_no;
  logic       rw;
  logic [7:0] index;
  logic       master_nack;
  logic       wr_en;
  logic [7:0] rd_data;

  wire byte_done  = (bit_cnt == `ISC_BYTE_BITS);
  wire addr_match = (shreg[7:1] == {`ISC_ADDR_HI, addr_lsb});
  wire [1:0] next_byte_no = (byte_no == `ISC_BYTE_DATA) ?
                            byte_no : byte_no + 2'h1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      bit_cnt     <= `ISC_BIT_ZERO;
      shreg       <= `ISC_RST_ZERO;
      tx_sh       <= `ISC_RST_ZERO;
      byte_no     <= `ISC_BYTE_ADDR;
      rw          <= 1'b0;
      index       <= `ISC_RST_ZERO;
      master_nack <= 1'b1;
      wr_en       <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else begin
      wr_en <= 1'b0;
      if (wr_en) index <= index + 8'h01;
      case (state)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + `ISC_BIT_ONE;
          end else if (scl_fall && byte_done) begin
            bit_cnt <= `ISC_BIT_ZERO;
            byte_no <= next_byte_no;
            if (byte_no == `ISC_BYTE_ADDR) begin
              if (addr_match) begin
                rw       <= shreg[0];
                sda_oe_n <= 1'b0;
                state    <= ST_RX_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              sda_oe_n <= 1'b0;
              state    <= ST_RX_ACK;
              if (byte_no == `ISC_BYTE_INDEX) index <= shreg;
              else wr_en <= 1'b1;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              tx_sh    <= rd_data;
              sda_oe_n <= rd_data[7];
              bit_cnt  <= `ISC_BIT_ONE;
              index    <= index + 8'h01;
              state    <= ST_TX;
            end else begin
              sda_oe_n <= 1'b1;
              state    <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_oe_n <= 1'b1;
              state    <= ST_TX_ACK;
            end else begin
              tx_sh    <= {tx_sh[6:0], 1'b0};
              sda_oe_n <= tx_sh[6];
              bit_cnt  <= bit_cnt + `ISC_BIT_ONE;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            master_nack <= sda_s;
          end else if (scl_fall) begin
            if (master_nack) begin
              state <= ST_IDLE;
            end else begin
              tx_sh    <= rd_data;
              sda_oe_n <= rd_data[7];
              bit_cnt  <= `ISC_BIT_ONE;
              index    <= index + 8'h01;
              state    <= ST_TX;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (start_cond) begin
        state    <= ST_RX;
        bit_cnt  <= `ISC_BIT_ZERO;
        byte_no  <= `ISC_BYTE_ADDR;
        rw       <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
    end
  end

  // Open-drain data only; clock is never driven
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  isc_regfile u_regs (
    .ref_clk               (ref_clk),
    .rst_n                 (rst_n),
    .wr_en                 (wr_en),
    .idx                   (index),
    .wdata                 (shreg),
    .fault_status          (fault_status),
    .rd_data               (rd_data),
    .low_power_standby_bit (low_power_standby_bit),
    .power_stage_off       (power_stage_off),
    .supplies_down         (supplies_down),
    .hpf_bypass            (hpf_bypass),
    .digital_boost         (digital_boost),
    .rate_range_select     (rate_range_select),
    .audio_format          (audio_format),
    .fade_enable           (fade_enable),
    .mute_right            (mute_right),
    .mute_left             (mute_left),
    .left_vol              (left_vol),
    .right_vol             (right_vol),
    .output_stage_bits     (output_stage_bits),
    .fault_config_bits     (fault_config_bits),
    .clip_threshold_level  (clip_threshold_level)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_addr_end;
    state == ST_RX && byte_no == `ISC_BYTE_ADDR && scl_fall && byte_done;
  endsequence

  sequence s_read_load;
    state == ST_RX_ACK && rw && scl_fall && !start_cond && !stop_cond;
  endsequence

  property p_start_rx;
    @(posedge ref_clk) disable iff (!rst_n)
      start_cond |=> state == ST_RX && bit_cnt == `ISC_BIT_ZERO && sda_oe_n;
  endproperty
  a_start_rx: assert property (p_start_rx)
    else $error("start did not open a byte");

  property p_stop_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_cond && !start_cond |=> state == ST_IDLE && sda_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not release bus");

  property p_addr_nomatch;
    @(posedge ref_clk) disable iff (!rst_n)
      s_addr_end and (!addr_match && !start_cond) |=>
        sda_oe_n && state == ST_IDLE;
  endproperty
  a_addr_nomatch: assert property (p_addr_nomatch)
    else $error("acknowledged a foreign address");

  property p_ack_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      s_addr_end and (addr_match && !start_cond && !stop_cond) |=>
        !sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released early");

  property p_idle_released;
    @(posedge ref_clk) disable iff (!rst_n)
      state == ST_IDLE |-> sda_oe_n;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("data driven while idle");

  property p_rx_msb_first;
    @(posedge ref_clk) disable iff (!rst_n)
      state == ST_RX && scl_rise && !start_cond |=>
        shreg[0] == $past(sda_s) && shreg[7:1] == $past(shreg[6:0]);
  endproperty
  a_rx_msb_first: assert property (p_rx_msb_first)
    else $error("received bit not shifted in");

  property p_write_advance;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_en && !$past(start_cond) |=> index == $past(index) + 8'h01;
  endproperty
  a_write_advance: assert property (p_write_advance)
    else $error("index did not advance after write");

  property p_read_first_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      s_read_load |=> state == ST_TX && sda_oe_n == $past(rd_data[7])
        && index == $past(index) + 8'h01;
  endproperty
  a_read_first_bit: assert property (p_read_first_bit)
    else $error("read byte not launched");

  property p_write_continues;
    @(posedge ref_clk) disable iff (!rst_n)
      state == ST_RX_ACK && !rw && scl_fall && !start_cond && !stop_cond
        |=> state == ST_RX && sda_oe_n ##1 state != ST_RX_ACK;
  endproperty
  a_write_continues: assert property (p_write_continues)
    else $error("write stream not continued");

  property p_no_drive_high;
    @(posedge ref_clk) disable iff (!rst_n)
      !sda_oe_n |-> sda_out == 1'b0 && state != ST_IDLE;
  endproperty
  a_no_drive_high: assert property (p_no_drive_high)
    else $error("data pin driven wrongly");

endmodule // isc_control_port

/* File: tb/isc_master_model.sv */
// Bus master model for the two-wire control link
`timescale 1ns/1ps

module isc_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule // isc_master_model

/* File: tb/isc_control_port_test.sv */
// Self-checking bench of the two-wire control port
`timescale 1ns/1ps
`include "isc_regs.svh"

module isc_control_port_test;
  import isc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic [3:0] fault_status = 4'h5;
  logic scl, sda_drv, sda_out, sda_oe_n, sda_wire, ack;
  logic sb, off, down;
  logic hpf, rate, fade, mr, ml;
  logic [1:0] boost;
  logic [6:0] osb;
  logic [3:0] fcb;
  logic [7:0] lvol, rvol, d;
  logic [19:0] clip;
  isc_fmt_t fmt;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rows [12] = '{32'h01fd_a6a6, 32'h0214_ffbf,
    32'h0380_ff83, 32'h04cf_1212, 32'h05cf_3434, 32'h0651_aaab,
    32'h0700_ff00, 32'h0805_fff5, 32'h10ff_5a5a, 32'h11fc_3c3c,
    32'h005a_ff5a, 32'h0c00_ff00};

  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  always #5 ref_clk = ~ref_clk;

  isc_master_model MST (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

  isc_control_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_strap_pin(strap), .fault_status(fault_status),
    .low_power_standby_bit(sb), .power_stage_off(off),
    .supplies_down(down), .hpf_bypass(hpf), .digital_boost(boost),
    .rate_range_select(rate), .audio_format(fmt), .fade_enable(fade),
    .mute_right(mr), .mute_left(ml), .left_vol(lvol), .right_vol(rvol),
    .output_stage_bits(osb), .fault_config_bits(fcb),
    .clip_threshold_level(clip));

  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ack %b expected %b", $time, got, exp);
    end
  endtask

  task automatic adr(input logic rw, input logic lsb, input logic exp);
    MST.start();
    MST.wbyte({`ISC_ADDR_HI, lsb, rw}, ack);
    chk_ack(ack, exp);
  endtask

  task automatic set_idx(input logic [7:0] idx);
    adr(1'b0, strap, 1'b1);
    MST.wbyte(idx, ack);
    chk_ack(ack, 1'b1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    set_idx(idx);
    MST.wbyte(dat, ack);
    chk_ack(ack, 1'b1);
    MST.stop();
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    set_idx(idx);
    adr(1'b1, strap, 1'b1);
    MST.rbyte(1'b1, d);
    chk_val(20'(d), 20'(exp));
    MST.stop();
  endtask

  initial begin
    for (int w = 0; w < 90000; w++) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t run limit reached", $time);
    finish_test();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 12; i++) begin
      rd(rows[i][31:24], rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], rows[i][7:0]);
    end
    chk_val(clip, 20'ha568f);
    chk_val(20'({hpf, boost, rate, fade, mr, ml, osb, fcb}), 20'h3_fd5f);
    chk_val(20'(rvol), 20'h34);
    for (int c = 0; c < 8; c++) begin
      wr(8'h02, 8'(c));
      chk_val(20'(fmt), c < 6 ? 20'(c) : 20'(FMT_RSVD));
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h01, 8'(p));
      chk_val(20'({sb, off, down}), 20'({p == 3, p != 1, p[0] == 0}));
    end
    set_idx(8'h04);
    MST.wbyte(8'h11, ack);
    chk_ack(ack, 1'b1);
    MST.wbyte(8'h22, ack);
    chk_ack(ack, 1'b1);
    MST.stop();
    chk_val(20'({lvol, rvol}), 20'h1122);
    set_idx(8'h04);
    adr(1'b1, strap, 1'b1);
    MST.rbyte(1'b0, d);
    chk_val(20'(d), 20'h11);
    MST.rbyte(1'b1, d);
    chk_val(20'(d), 20'h22);
    MST.stop();
    adr(1'b0, ~strap, 1'b0);
    MST.stop();
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    strap = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk_val(clip, 20'hf_ffff);
    rd(8'h04, 8'hcf);
    adr(1'b0, 1'b0, 1'b0);
    MST.stop();
    finish_test();
  end
endmodule // isc_control_port_test
